// file: pkg/ssa_defs.svh
/*
  Constants of the security supervisor: register offsets, field
  positions, reset values and timing counts.
  Assumes it is included by bare name from the package and the module.
*/
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH

// ************************************************************
// Register offsets (byte addresses, one word each)
// ************************************************************
`define SSA_OFS_STAT   8'h00
`define SSA_OFS_CLR    8'h04
`define SSA_OFS_EN     8'h08
`define SSA_OFS_REACT  8'h0C
`define SSA_OFS_SEC    8'h10
`define SSA_OFS_RIGHTS 8'h14
`define SSA_OFS_DWIN   8'h18
`define SSA_OFS_PWIN   8'h1C
`define SSA_OFS_EXEC   8'h20
`define SSA_OFS_MODE   8'h24
`define SSA_OFS_KEY    8'h28
`define SSA_OFS_TRACE  8'h2C

// ************************************************************
// Fields and widths
// ************************************************************
`define SSA_DET_N      7
`define SSA_ST_W       9
`define SSA_ST_FAULT   7
`define SSA_ST_TRREJ   8
`define SSA_SEC_WEN    0
`define SSA_SEC_LOCK   1
`define SSA_SEC_PRIV   2
`define SSA_MR_DRD     0
`define SSA_MR_DWR     1
`define SSA_MR_PFE     2
`define SSA_MODE_NORM  0
`define SSA_MODE_TEST  1
`define SSA_NVM_BIT    15
`define SSA_PAGE_HI    14
`define SSA_PAGE_LO    12

// ************************************************************
// Reset values and timing
// ************************************************************
`define SSA_RST_REACT  7'h00
`define SSA_RST_RIGHTS 3'h7
`define SSA_RST_WIN    32'hFFFF_0000
`define SSA_RST_EXEC   8'hFF
`define SSA_WIN_CYC    8'h80
`define SSA_FILT_CYC   4'h8

`endif

// file: pkg/ssa_pkg.sv
/*
  Types of the security supervisor.
  Assumes ssa_defs.svh sits on the include path.
*/
package ssa_pkg;
  `include "ssa_defs.svh"

  typedef enum logic [1:0] {
    ssa_lc_test   = 2'b00,
    ssa_lc_auth   = 2'b01,
    ssa_lc_normal = 2'b10
  } ssa_lc_t;

  typedef logic [15:0] ssa_addr_t;
endpackage : ssa_pkg

// file: hdl/ssa_supervisor.sv
/*
  Security supervisor: detector latching and reaction, pad filters,
  register write lock, address filter with fast interrupt, test to
  normal life cycle with traceability freeze.
  Assumes one 250 MHz clock, an Avalon-MM master on the same clock and
  a core that reports mode and every bus access on that clock.
*/
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ssa_defs.svh"

module ssa_supervisor
  import ssa_pkg::*;
#(
  parameter logic [31:0] TEST_KEY = 32'h1234_ABCD // Arbitrary value
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 priv_mode,
  input  wire logic [`SSA_DET_N-1:0] det_pin,
  input  wire logic                 pad_rst_raw,
  input  wire logic                 pad_clk_raw,
  input  wire logic                 mon_valid,
  input  wire ssa_addr_t            mon_addr,
  input  wire logic                 mon_write,
  input  wire logic                 mon_fetch,
  output logic                      irq,
  output logic                      fast_nonmaskable_irq,
  output logic                      chip_reset_req,
  output logic                      filt_pad_rst,
  output logic                      filt_pad_clk,
  output logic                      normal_mode,
  output logic                      test_access
);

  // ************************************************************
  // Address window decode
  // ************************************************************
  function automatic logic in_win(input ssa_addr_t a,
                                  input logic [31:0] w);
    in_win = (a >= w[15:0]) && (a <= w[31:16]);
  endfunction : in_win

  logic                  wait_r;
  logic [31:0]           rdata_r;
  logic [31:0]           rd_nxt;
  logic                  wr_acc;
  logic [`SSA_DET_N-1:0] det_s1_r;
  logic [`SSA_DET_N-1:0] det_s2_r;
  logic [`SSA_ST_W-1:0]  stat_r;
  logic [`SSA_ST_W-1:0]  en_r;
  logic [`SSA_ST_W-1:0]  stat_set;
  logic [`SSA_ST_W-1:0]  stat_clr;
  logic [`SSA_DET_N-1:0] react_r;
  logic                  sec_wen_r;
  logic                  lock_r;
  logic [7:0]            win_cnt_r;
  logic                  sec_ok;
  logic [2:0]            rights_r;
  logic [31:0]           dwin_r;
  logic [31:0]           pwin_r;
  logic [7:0]            exec_r;
  logic [31:0]           trace_r;
  ssa_lc_t               lc_r;
  logic                  key_ok;
  logic                  trace_rej;
  logic                  nvm_hit;
  logic                  exec_bad;
  logic                  illegal;
  logic                  irq_r;
  logic                  fiq_r;
  logic                  chip_rst_r;
  logic [1:0]            pad_raw;
  logic [1:0]            pad_filt;

  // ************************************************************
  // Avalon slave: one wait cycle, then the answer
  // ************************************************************
  assign wr_acc = avs_write && !wait_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (wait_r && avs_read) begin
      rdata_r <= rd_nxt;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address)
      `SSA_OFS_STAT:   rd_nxt[`SSA_ST_W-1:0] = stat_r;
      `SSA_OFS_EN:     rd_nxt[`SSA_ST_W-1:0] = en_r;
      `SSA_OFS_REACT:  rd_nxt[`SSA_DET_N-1:0] = react_r;
      `SSA_OFS_SEC: begin
        rd_nxt[`SSA_SEC_WEN]  = sec_wen_r;
        rd_nxt[`SSA_SEC_LOCK] = lock_r;
        rd_nxt[`SSA_SEC_PRIV] = priv_mode;
      end
      `SSA_OFS_RIGHTS: rd_nxt[2:0] = rights_r;
      `SSA_OFS_DWIN:   rd_nxt = dwin_r;
      `SSA_OFS_PWIN:   rd_nxt = pwin_r;
      `SSA_OFS_EXEC:   rd_nxt[7:0] = exec_r;
      `SSA_OFS_MODE: begin
        rd_nxt[`SSA_MODE_NORM] = (lc_r == ssa_lc_normal);
        rd_nxt[`SSA_MODE_TEST] = (lc_r == ssa_lc_auth);
      end
      `SSA_OFS_TRACE:  rd_nxt = trace_r;
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // Pad filters, not reachable from software
  // ************************************************************
  // A level must hold for the full count; shorter pulses and fast
  // toggling never reach the output.
  assign pad_raw = {pad_clk_raw, pad_rst_raw};

  for (genvar g = 0; g < 2; g++) begin : g_pad
    logic       s1_r;
    logic       s2_r;
    logic       filt_r;
    logic [3:0] cnt_r;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
      end else begin
        s1_r <= pad_raw[g];
        s2_r <= s1_r;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt_r  <= 4'h0;
        filt_r <= 1'b0;
      end else if (s2_r == filt_r) begin
        cnt_r <= 4'h0;
      end else if (cnt_r == `SSA_FILT_CYC - 4'h1) begin
        cnt_r  <= 4'h0;
        filt_r <= s2_r;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end

    assign pad_filt[g] = filt_r;
  end

  assign filt_pad_rst = pad_filt[0];
  assign filt_pad_clk = pad_filt[1];

  // ************************************************************
  // Detectors, status and reaction
  // ************************************************************
  // No register gates the detector path into the status; only the interrupt (en_r) and the reaction are soft.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_s1_r <= '0;
      det_s2_r <= '0;
    end else begin
      det_s1_r <= det_pin;
      det_s2_r <= det_s1_r;
    end
  end

  assign stat_set = {trace_rej, illegal, det_s2_r};
  assign stat_clr = (wr_acc && avs_address == `SSA_OFS_CLR) ?
                    avs_writedata[`SSA_ST_W-1:0] : '0;

  // Set beats clear so a same-cycle event survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & en_r);
    end
  end

  // Held until the chip reset comes back through rst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chip_rst_r <= 1'b0;
    end else if (|(det_s2_r & react_r)) begin
      chip_rst_r <= 1'b1;
    end
  end

  // ************************************************************
  // Write lock of the security registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_cnt_r <= 8'h00;
    end else if (win_cnt_r != `SSA_WIN_CYC) begin
      win_cnt_r <= win_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_wen_r <= 1'b0;
      lock_r    <= 1'b0;
    end else begin
      if (wr_acc && avs_address == `SSA_OFS_SEC &&
          win_cnt_r != `SSA_WIN_CYC && !lock_r) begin
        sec_wen_r <= avs_writedata[`SSA_SEC_WEN];
      end
      if (win_cnt_r == `SSA_WIN_CYC && !sec_wen_r) begin
        lock_r <= 1'b1;
      end
    end
  end

  assign sec_ok = wr_acc && (priv_mode || (sec_wen_r && !lock_r));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r     <= '0;
      react_r  <= `SSA_RST_REACT;
      rights_r <= `SSA_RST_RIGHTS;
      dwin_r   <= `SSA_RST_WIN;
      pwin_r   <= `SSA_RST_WIN;
      exec_r   <= `SSA_RST_EXEC;
    end else if (sec_ok) begin
      case (avs_address)
        `SSA_OFS_EN:     en_r     <= avs_writedata[`SSA_ST_W-1:0];
        `SSA_OFS_REACT:  react_r  <= avs_writedata[`SSA_DET_N-1:0];
        `SSA_OFS_RIGHTS: rights_r <= avs_writedata[2:0];
        `SSA_OFS_DWIN:   dwin_r   <= avs_writedata;
        `SSA_OFS_PWIN:   pwin_r   <= avs_writedata;
        `SSA_OFS_EXEC:   exec_r   <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Address filter and execute check
  // ************************************************************
  assign nvm_hit  = mon_addr[`SSA_NVM_BIT];
  assign exec_bad = mon_fetch && nvm_hit &&
                    !exec_r[mon_addr[`SSA_PAGE_HI:`SSA_PAGE_LO]];

  always_comb begin
    if (!mon_valid) begin
      illegal = 1'b0;
    end else if (mon_fetch) begin
      illegal = !in_win(mon_addr, pwin_r) || !rights_r[`SSA_MR_PFE] ||
                exec_bad;
    end else begin
      illegal = !in_win(mon_addr, dwin_r) ||
                !rights_r[mon_write ? `SSA_MR_DWR : `SSA_MR_DRD];
    end
  end

  // No enable: the fast interrupt cannot be masked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fiq_r <= 1'b0;
    end else begin
      fiq_r <= illegal;
    end
  end

  // ************************************************************
  // Life cycle and traceability
  // ************************************************************
  assign key_ok = wr_acc && avs_address == `SSA_OFS_KEY &&
                  avs_writedata == TEST_KEY;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lc_r <= ssa_lc_test;
    end else begin
      unique case (lc_r)
        ssa_lc_test, ssa_lc_auth: begin
          if (wr_acc && avs_address == `SSA_OFS_MODE &&
              avs_writedata[`SSA_MODE_NORM]) begin
            lc_r <= ssa_lc_normal;
          end else if (key_ok) begin
            lc_r <= ssa_lc_auth;
          end
        end
        ssa_lc_normal: lc_r <= ssa_lc_normal;
        default:       lc_r <= ssa_lc_normal;
      endcase
    end
  end

  assign trace_rej = wr_acc && avs_address == `SSA_OFS_TRACE &&
                     lc_r != ssa_lc_auth;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trace_r <= 32'h0000_0000;
    end else if (wr_acc && avs_address == `SSA_OFS_TRACE &&
                 lc_r == ssa_lc_auth) begin
      trace_r <= avs_writedata;
    end
  end

  assign avs_readdata         = rdata_r;
  assign avs_waitrequest      = wait_r;
  assign irq                  = irq_r;
  assign fast_nonmaskable_irq = fiq_r;
  assign chip_reset_req       = chip_rst_r;
  // State codes chosen so each flag is one state bit
  assign normal_mode          = lc_r[1];
  assign test_access          = lc_r[0];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_lock_window: assert property (
    (win_cnt_r == `SSA_WIN_CYC && !sec_wen_r) |=> lock_r)
    else $error("write lock not set after window");
  a_lock_sticky: assert property (lock_r |=> lock_r)
    else $error("write lock released");
  a_det_capture: assert property (
    det_s2_r[0] |=> stat_r[0])
    else $error("detector event not latched");
  a_det_sticky: assert property (
    (stat_r[1] && !stat_clr[1]) |=> stat_r[1])
    else $error("detector flag lost");
  a_react_reset: assert property (
    |(det_s2_r & react_r) |=> chip_reset_req [*2])
    else $error("reset reaction missing");
  a_fiq_illegal: assert property (
    (mon_valid && !mon_fetch && !in_win(mon_addr, dwin_r))
    |=> fast_nonmaskable_irq)
    else $error("illegal data access not trapped");
  a_exec_fetch: assert property (
    (mon_valid && exec_bad) |=> fast_nonmaskable_irq ##1 stat_r[`SSA_ST_FAULT])
    else $error("forbidden fetch not trapped");
  a_normal_oneway: assert property (normal_mode |=> normal_mode)
    else $error("returned from normal mode");
  a_trace_frozen: assert property (normal_mode |=> $stable(trace_r))
    else $error("trace data changed in normal mode");
  a_test_key: assert property (
    $rose(test_access) |-> $past(key_ok))
    else $error("test access without password");

  c_det_reset: cover property (|(det_s2_r & react_r) ##1 chip_reset_req);
  c_fiq:       cover property (mon_valid ##1 fast_nonmaskable_irq);
  c_lock:      cover property ($rose(lock_r));
  c_normal:    cover property (test_access ##[1:20] normal_mode);

endmodule : ssa_supervisor

// file: bench/ssa_core_model.sv
/*
  Core model: issues one monitored bus access per call of access.
  Assumes the supervisor samples mon_* at the rising edge of clk.
*/
`timescale 1ns/1ps
module ssa_core_model (
  input  wire logic        clk,
  output logic             mon_valid,
  output logic [15:0]      mon_addr,
  output logic             mon_write,
  output logic             mon_fetch
);
  initial begin
    mon_valid = 1'b0;
    mon_addr  = 16'h0000;
    mon_write = 1'b0;
    mon_fetch = 1'b0;
  end

  // One cycle of valid; idle address inverted so a stale one never looks live
  task automatic access(input logic [15:0] addr, input logic wr, input logic fe);
    @(posedge clk);
    mon_valid <= 1'b1;
    mon_addr  <= addr;
    mon_write <= wr;
    mon_fetch <= fe;
    @(posedge clk);
    mon_valid <= 1'b0;
    mon_addr  <= ~addr;
    mon_write <= 1'b0;
    mon_fetch <= 1'b0;
  endtask : access
endmodule : ssa_core_model

// file: bench/ssa_supervisor_tb_top.sv
/*
  Self-checking bench of the security supervisor.
  Assumes the core model file and the package are compiled first.
*/
`timescale 1ns/1ps
`include "ssa_defs.svh"
module ssa_supervisor_tb_top;
  import ssa_pkg::*;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, priv_mode;
  logic        pad_rst_raw, pad_clk_raw, mon_valid, mon_write, mon_fetch;
  logic        irq, fast_nonmaskable_irq, chip_reset_req, filt_pad_rst, filt_pad_clk;
  logic        normal_mode, test_access;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [6:0]  det_pin;
  ssa_addr_t   mon_addr;
  int          n_mismatch, total_checks;

  ssa_supervisor u_ssa_supervisor (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .priv_mode(priv_mode),
    .det_pin(det_pin), .pad_rst_raw(pad_rst_raw), .pad_clk_raw(pad_clk_raw),
    .mon_valid(mon_valid), .mon_addr(mon_addr), .mon_write(mon_write), .mon_fetch(mon_fetch),
    .irq(irq), .fast_nonmaskable_irq(fast_nonmaskable_irq), .chip_reset_req(chip_reset_req),
    .filt_pad_rst(filt_pad_rst), .filt_pad_clk(filt_pad_clk), .normal_mode(normal_mode),
    .test_access(test_access));

  ssa_core_model u_ssa_core_model (.clk(clk), .mon_valid(mon_valid), .mon_addr(mon_addr),
    .mon_write(mon_write), .mon_fetch(mon_fetch));

  always #2 clk = ~clk;

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // Request held until the edge that sees waitrequest low; data taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      wrap_up();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic acc(input logic [15:0] a, input logic w, input logic f, input logic exp);
    u_ssa_core_model.access(a, w, f);
    #1;
    chk(fast_nonmaskable_irq, exp);
  endtask : acc

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_defaults;
    rdchk(`SSA_OFS_REACT, 32'h0000_0000);
    rdchk(`SSA_OFS_RIGHTS, 32'h0000_0007);
    rdchk(`SSA_OFS_DWIN, 32'hFFFF_0000);
    rdchk(`SSA_OFS_PWIN, 32'hFFFF_0000);
    rdchk(`SSA_OFS_EXEC, 32'h0000_00FF);
    rdchk(`SSA_OFS_MODE, 32'h0000_0000);
    rdchk(8'h3C, 32'h0000_0000);
    chk({normal_mode, test_access, chip_reset_req, irq}, 32'h0);
    bus(1'b1, `SSA_OFS_STAT, 32'hFFFF_FFFF);
    rdchk(`SSA_OFS_STAT, 32'h0000_0000);
    bus(1'b1, `SSA_OFS_SEC, 32'h0000_0001);
    rdchk(`SSA_OFS_SEC, 32'h0000_0001);
    bus(1'b1, `SSA_OFS_EN, 32'h0000_007F);
    rdchk(`SSA_OFS_EN, 32'h0000_007F);
    $display("Done: defaults");
  endtask : t_defaults

  task automatic t_lock;
    do_reset();
    wt(130);
    bus(1'b1, `SSA_OFS_SEC, 32'h0000_0001);
    rdchk(`SSA_OFS_SEC, 32'h0000_0002);
    bus(1'b1, `SSA_OFS_EN, 32'h0000_007F);
    rdchk(`SSA_OFS_EN, 32'h0000_0000);
    priv_mode <= 1'b1;
    bus(1'b1, `SSA_OFS_EN, 32'h0000_007F);
    rdchk(`SSA_OFS_EN, 32'h0000_007F);
    rdchk(`SSA_OFS_SEC, 32'h0000_0006);
    $display("Done: lock");
  endtask : t_lock

  task automatic t_detect;
    for (int i = 0; i < 7; i++) begin
      det_pin <= 7'h01 << i;
      wt(6);
      det_pin <= 7'h00;
      wt(3);
      rdchk(`SSA_OFS_STAT, 32'h1 << i);
      chk({chip_reset_req, irq}, 32'h1);
      bus(1'b1, `SSA_OFS_CLR, 32'h1 << i);
      wt(2);
      rdchk(`SSA_OFS_STAT, 32'h0000_0000);
      chk(irq, 32'h0);
    end
    bus(1'b1, `SSA_OFS_REACT, 32'h0000_0040);
    det_pin <= 7'h40;
    wt(6);
    chk(chip_reset_req, 32'h1);
    det_pin <= 7'h00;
    do_reset();
    wt(1);
    chk(chip_reset_req, 32'h0);
    $display("Done: detect");
  endtask : t_detect

  task automatic t_fault;
    bus(1'b1, `SSA_OFS_RIGHTS, 32'h0000_0005);
    acc(16'h0100, 1'b1, 1'b0, 1'b1);
    wt(1);
    chk(fast_nonmaskable_irq, 32'h0);
    acc(16'h0100, 1'b0, 1'b0, 1'b0);
    rdchk(`SSA_OFS_STAT, 32'h0000_0080);
    bus(1'b1, `SSA_OFS_DWIN, 32'h00FF_0000);
    acc(16'h0200, 1'b0, 1'b0, 1'b1);
    bus(1'b1, `SSA_OFS_EXEC, 32'h0000_00FE);
    acc(16'h8000, 1'b0, 1'b1, 1'b1);
    acc(16'h9000, 1'b0, 1'b1, 1'b0);
    $display("Done: fault");
  endtask : t_fault

  task automatic t_life;
    bus(1'b1, `SSA_OFS_TRACE, 32'h0000_00A5);
    rdchk(`SSA_OFS_STAT, 32'h0000_0180);
    bus(1'b1, `SSA_OFS_KEY, 32'h0BAD_0000);
    wt(2);
    chk(test_access, 32'h0);
    bus(1'b1, `SSA_OFS_KEY, 32'h1234_ABCD);
    wt(2);
    chk(test_access, 32'h1);
    bus(1'b1, `SSA_OFS_TRACE, 32'h0000_005A);
    rdchk(`SSA_OFS_TRACE, 32'h0000_005A);
    bus(1'b1, `SSA_OFS_MODE, 32'h0000_0001);
    wt(2);
    chk({normal_mode, test_access}, 32'h2);
    bus(1'b1, `SSA_OFS_CLR, 32'h0000_0100);
    bus(1'b1, `SSA_OFS_TRACE, 32'h0000_0077);
    rdchk(`SSA_OFS_TRACE, 32'h0000_005A);
    rdchk(`SSA_OFS_STAT, 32'h0000_0180);
    bus(1'b1, `SSA_OFS_KEY, 32'h1234_ABCD);
    bus(1'b1, `SSA_OFS_MODE, 32'h0000_0000);
    rdchk(`SSA_OFS_MODE, 32'h0000_0001);
    $display("Done: life");
  endtask : t_life

  task automatic t_pad;
    int n;
    pad_rst_raw <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      pad_clk_raw <= ~pad_clk_raw;
      if (n == 2) pad_rst_raw <= 1'b0;
    end
    wt(1);
    chk({filt_pad_rst, filt_pad_clk}, 32'h0);
    pad_rst_raw <= 1'b1;
    n = 0;
    while (filt_pad_rst !== 1'b1 && n < 30) begin
      wt(1);
      n++;
    end
    chk(n >= 8 && n <= 14, 32'h1);
    $display("Done: pad");
  endtask : t_pad

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    priv_mode = 1'b0;
    det_pin = 7'h00;
    pad_rst_raw = 1'b0;
    pad_clk_raw = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    do_reset();
    t_defaults();
    t_lock();
    t_detect();
    t_fault();
    t_life();
    t_pad();
    wrap_up();
  end
endmodule : ssa_supervisor_tb_top
